// ===== hw/xfade_core.sv
// Purpose: Frame control, window edge selection and output cross-fade for
//          switching between transform and linear-prediction synthesis.
// Assumes: Upstream stages deliver one sample per valid strobe in frame order;
//          decoder control writes mode and previous mode before each frame.
// Notes:   Arithmetic transforms live upstream; this block steers and mixes.
`timescale 1ns/1ps

// Overview of operation
// - Transient frames window each short sub-frame, then inverse DCT-IV and un-aliasing.
// - Long asymmetric window next to short symmetric window uses full overlap.
// - Long-to-short: left is long window short slope 8.75ms, right half/smallest_overlap_mode; no edge output here selects half or minimum overlap.
// - Short-to-long: left side uses half or smallest_overlap_mode overlap; no edge output here selects half or minimum overlap.
// - Short-to-long right: long slope truncated to 8.75ms, dropping last 5.625ms.
// - Last 1.25ms of truncated slope multiplied by 1.25ms smallest_overlap_mode slope.
// - Second inverse transform over lowest coefficients at prediction rate.
// - Output rate below prediction rate pads spectrum with zeros.
// - Low-rate synthesis uses same procedure, only length differs.
// - Prediction memories updated before a prediction frame after transform frame.
// - Three transition modes choose memory handling and cross-fade.
// - Mode one clears resampler, emphasis, synthesis, excitation, bass memories.
// - Mode one loads fixed coefficients, spectral lines and gain memories.
// - Mode one forces transition coding, no past adaptive codebook.
// - Mode one decodes end-of-frame coefficients only, used for all subframes.
// - Mode one: first D samples are old transform; overlap-add aliased memory.
// - Mode two refreshes memories from low-rate signal; output-rate signal out.
// - Mode two: transform, linear fade after 0.25ms, then prediction only.
// - Fade ends 1.25ms at 8kHz else 2.3125ms, in a 20ms frame.
// - Mode three resets or extrapolates memories, fades like mode one.
module xfade_core (
  input  wire logic                  clk,
  input  wire logic                  resetn,
  // AHB-Lite slave.
  input  wire logic                  hsel,
  input  wire logic [7:0]            haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic      [31:0]           hrdata,
  output logic                       hreadyout,
  output logic                       hresp,
  // Sample stream.
  input  wire xfade_pkg::sample_in_t smp_in,
  output logic      [15:0]           smp_out,
  output logic                       smp_out_valid,
  output logic      [15:0]           lowrate_out,
  output logic                       lowrate_out_valid,
  // Memory commands and window edge controls to synthesis stages.
  output xfade_pkg::mem_cmd_t        mem_cmd,
  output logic                       mem_cmd_valid,
  output logic                       full_overlap,
  output logic                       slope_trunc,
  output logic                       slope_soften,
  output logic                       short_inv_en,
  output logic                       zero_pad_en
);

  // ==========================================================================
  // Helpers
  // ==========================================================================
  // Samples in a span of microseconds at a rate in kHz, rounded down.
  function automatic logic [15:0] us_to_n(input int us, input int khz);
    us_to_n = 16'((us * khz) / 1000);
  endfunction

  // Q15 product of a sample and a weight.
  function automatic logic [15:0] qmul(input logic [15:0] s, input logic [15:0] w);
    logic signed [31:0] p;
    p = $signed(s) * $signed({1'b0, w[14:0]});
    qmul = p[30:15];
  endfunction

  // ==========================================================================
  // Registers and bus
  // ==========================================================================
  logic [31:0] ctrl_q, ctrl_d;
  logic [31:0] cfg_q, cfg_d;
  logic [7:0]  addr_q;
  logic        wr_q;
  logic        rd_q;
  xfade_pkg::xf_state_t state_q, state_d;
  logic [15:0] n_q, n_d;
  logic [15:0] frames_q;
  xfade_pkg::trans_mode_t mode_q;
  logic        prev_hq_q;

  wire         bus_req   = hsel & hready & htrans[1];
  wire         wr_ctrl   = wr_q & (addr_q == xfade_pkg::ADDR_CTRL);
  wire         wr_cfg    = wr_q & (addr_q == xfade_pkg::ADDR_CFG);
  wire         start     = wr_ctrl & hwdata[xfade_pkg::CTRL_START_BIT];
  wire [1:0]   mode_w    = ctrl_q[xfade_pkg::CTRL_MODE_LSB +: 2];
  wire         rate8k    = cfg_q[xfade_pkg::CFG_RATE8K_BIT];
  wire [2:0]   rate_idx  = cfg_q[xfade_pkg::CFG_RATELSB +: 3];
  wire         busy      = (state_q != xfade_pkg::ST_IDLE);

  // Output rate in kHz from the configured index.
  wire [15:0]  rate_khz  = (rate_idx > 3'd4) ? 16'd16 : 16'(xfade_pkg::RATE_KHZ[rate_idx]);
  wire [15:0]  d_ltp     = 16'((32'(xfade_pkg::LTP_DELAY_US) * rate_khz) / 1000);
  wire [15:0]  d_end     = rate8k ? us_to_n(xfade_pkg::XFADE_END_8K_US, 8)
                         : 16'(((32'(xfade_pkg::XFADE_END_US) * 16 + xfade_pkg::XFADE_END_FRAC16)
                                * rate_khz) / 16000);
  wire [15:0]  n_frame   = 16'((32'(xfade_pkg::FRAME_US) * rate_khz) / 1000);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      addr_q <= 8'h00;
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
      ctrl_q <= 32'h0000_0000;
      cfg_q  <= xfade_pkg::CFG_RESET;
    end else begin
      addr_q <= bus_req ? haddr : addr_q;
      wr_q   <= bus_req & hwrite;
      rd_q   <= bus_req & ~hwrite;
      ctrl_q <= ctrl_d;
      cfg_q  <= cfg_d;
    end
  end

  // Start self-clears; writes while a frame runs are ignored so the mode
  // cannot change halfway through a cross-fade.
  assign ctrl_d = (wr_ctrl & ~busy) ? {hwdata[31:1], 1'b0} : ctrl_q;
  assign cfg_d  = (wr_cfg & ~busy) ? hwdata : cfg_q;

  wire [31:0] status_w = {13'h0000, state_q, frames_q};
  assign hrdata    = ~rd_q ? 32'h0000_0000
                   : (addr_q == xfade_pkg::ADDR_CTRL)   ? ctrl_q
                   : (addr_q == xfade_pkg::ADDR_CFG)    ? cfg_q
                   : (addr_q == xfade_pkg::ADDR_STATUS) ? status_w
                   : (addr_q == xfade_pkg::ADDR_MEMCTL) ? {26'h0, mem_cmd}
                   : (addr_q == xfade_pkg::ADDR_COUNT)  ? {16'h0000, n_q}
                   : 32'h0000_0000;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // ==========================================================================
  // Window edge steering
  // ==========================================================================
  wire long_left  = ~cfg_q[xfade_pkg::CFG_SHORT_LEFT_BIT];
  wire long_right = ~cfg_q[xfade_pkg::CFG_SHORT_RIGHT_BIT];
  wire short_any  = cfg_q[xfade_pkg::CFG_SHORT_LEFT_BIT] | cfg_q[xfade_pkg::CFG_SHORT_RIGHT_BIT];

  assign short_inv_en = short_any;
  // A long neighbour of a short block takes the full overlap edge.
  assign full_overlap = short_any & (long_left | long_right);
  // Short-to-long: cut long slope to 8.75 ms and soften last 1.25 ms.
  assign slope_trunc  = cfg_q[xfade_pkg::CFG_SHORT_LEFT_BIT] & long_right;
  assign slope_soften = slope_trunc;
  // Output below prediction rate needs zero coefficients in the low-rate pass.
  // The prediction rate of 12.8 kHz is kept as 12, so a 12 kHz output is still below it.
  assign zero_pad_en  = (rate_khz <= 16'(xfade_pkg::CELP_KHZ_LO));

  // ==========================================================================
  // Frame sequencer
  // ==========================================================================
  always_comb begin
    state_d = state_q;
    n_d     = n_q;
    case (state_q)
      xfade_pkg::ST_IDLE: begin
        n_d = 16'h0000;
        if (start && hwdata[xfade_pkg::CTRL_MODE_LSB +: 2] != 2'b00) begin
          state_d = xfade_pkg::ST_MEMUPD;
        end
      end
      xfade_pkg::ST_MEMUPD: begin
        state_d = xfade_pkg::ST_HEAD;
      end
      xfade_pkg::ST_HEAD, xfade_pkg::ST_FADE, xfade_pkg::ST_TAIL: begin
        if (smp_in.valid) begin
          n_d = n_q + 16'h0001;
          if (n_d >= n_frame) begin
            state_d = xfade_pkg::ST_IDLE;
          end else if (n_d >= d_end) begin
            state_d = xfade_pkg::ST_TAIL;
          end else if (n_d >= d_ltp) begin
            state_d = xfade_pkg::ST_FADE;
          end
        end
      end
      default: state_d = xfade_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q   <= xfade_pkg::ST_IDLE;
      n_q       <= 16'h0000;
      frames_q  <= 16'h0000;
      mode_q    <= xfade_pkg::MODE_NONE;
      prev_hq_q <= 1'b0;
    end else begin
      state_q   <= state_d;
      n_q       <= n_d;
      frames_q  <= (busy && state_d == xfade_pkg::ST_IDLE) ? frames_q + 16'h0001 : frames_q;
      // Take the mode from the value being written, so the start write itself sets it.
      mode_q    <= (state_q == xfade_pkg::ST_IDLE) ? xfade_pkg::trans_mode_t'(ctrl_d[xfade_pkg::CTRL_MODE_LSB +: 2])
                                                   : mode_q;
      prev_hq_q <= (state_q == xfade_pkg::ST_IDLE) ? ctrl_d[xfade_pkg::CTRL_PREVHQ_BIT] : prev_hq_q;
    end
  end

  // ==========================================================================
  // Memory handling per mode
  // ==========================================================================
  wire m1 = (mode_q == xfade_pkg::MODE_ONE);
  wire m2 = (mode_q == xfade_pkg::MODE_TWO);
  wire m3 = (mode_q == xfade_pkg::MODE_THREE);
  wire ex = ctrl_q[xfade_pkg::CTRL_EXTRAP_BIT];
  xfade_pkg::mem_cmd_t mem_cmd_d;

  always_comb begin
    mem_cmd_d                 = '0;
    mem_cmd_d.clear_mems      = m1 | (m3 & ~ex);
    mem_cmd_d.load_fixed      = m1 | (m3 & ~ex);
    mem_cmd_d.force_tc        = m1;
    mem_cmd_d.end_lpc_only    = m1;
    mem_cmd_d.refresh_lowrate = m2;
    mem_cmd_d.extrapolate     = m3 & ex;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mem_cmd       <= '0;
      mem_cmd_valid <= 1'b0;
    end else begin
      mem_cmd       <= (state_q == xfade_pkg::ST_MEMUPD) ? mem_cmd_d : mem_cmd;
      mem_cmd_valid <= (state_q == xfade_pkg::ST_MEMUPD);
    end
  end

  // ==========================================================================
  // Output mixing
  // ==========================================================================
  // Linear weight (n - d_ltp) / (end - d_ltp) in Q15.
  wire [15:0] span   = (d_end > d_ltp) ? (d_end - d_ltp) : 16'h0001;
  wire [15:0] pos    = (n_q > d_ltp) ? (n_q - d_ltp) : 16'h0000;
  wire [31:0] w_num  = {1'b0, pos[14:0], 16'h0000} >> 1;
  wire [15:0] w_pred = 16'(w_num / {16'h0000, span});
  wire [15:0] w_xfm  = xfade_pkg::Q15_ONE - w_pred;
  wire [15:0] fade_s = qmul(smp_in.xfm, w_xfm) + qmul(smp_in.pred, w_pred);
  // Unweighted aliased memory is added as is, no window compensation.
  wire [15:0] ola_s  = smp_in.alias_mem + smp_in.pred;
  wire        head   = (state_q == xfade_pkg::ST_HEAD);
  wire        fade   = (state_q == xfade_pkg::ST_FADE);
  wire        m1_ola = m1 | m3;
  wire [15:0] mix_s  = m2 ? (head ? smp_in.xfm : fade ? fade_s : smp_in.pred)
                     : m1_ola ? ((head | fade) ? smp_in.xfm : ola_s)
                     : smp_in.xfm;
  wire        run    = (state_q == xfade_pkg::ST_HEAD) | fade | (state_q == xfade_pkg::ST_TAIL);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      smp_out           <= xfade_pkg::SAMPLE_ZERO;
      smp_out_valid     <= 1'b0;
      lowrate_out       <= xfade_pkg::SAMPLE_ZERO;
      lowrate_out_valid <= 1'b0;
    end else begin
      smp_out           <= (run & smp_in.valid) ? mix_s : smp_out;
      smp_out_valid     <= run & smp_in.valid;
      // Low-rate pass uses the same window and transform, only shorter.
      lowrate_out       <= (run & smp_in.valid) ? smp_in.lowrate : lowrate_out;
      lowrate_out_valid <= run & smp_in.valid & m2;
    end
  end

endmodule // xfade_core

// ===== hw/xfade_pkg.sv
// Purpose: Shared constants and types for the transform/prediction switch block.
// Assumes: 10 MHz clock, AHB-Lite register access, 16-bit samples.
// Notes:   Times are kept in microseconds; sample counts derive from the rate.
package xfade_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_CFG     = 8'h04;
  localparam logic [7:0] ADDR_STATUS  = 8'h08;
  localparam logic [7:0] ADDR_MEMCTL  = 8'h0C;
  localparam logic [7:0] ADDR_COUNT   = 8'h10;

  // CTRL fields.
  localparam int CTRL_START_BIT      = 0;
  localparam int CTRL_MODE_LSB       = 1;
  localparam int CTRL_PREVHQ_BIT     = 3;
  localparam int CTRL_EXTRAP_BIT     = 4;
  // CFG fields.
  localparam int CFG_RATE8K_BIT      = 0;
  localparam int CFG_RATELSB         = 1;
  localparam int CFG_SHORT_LEFT_BIT  = 4;
  localparam int CFG_SHORT_RIGHT_BIT = 5;
  localparam int CFG_OVL_MIN_BIT     = 6;
  localparam int CFG_QUARTER_BIT     = 7;
  localparam logic [31:0] CFG_RESET  = 32'h0000_0000;

  // ==========================================================================
  // Timing figures
  // ==========================================================================
  localparam int FRAME_US          = 20000;
  localparam int LTP_DELAY_US      = 250;
  localparam int XFADE_END_8K_US   = 1250;
  localparam int XFADE_END_US      = 2312; // 2.3125 ms rounded down in us.
  localparam int XFADE_END_FRAC16  = 8;    // Remaining 0.5 us in 1/16 us.
  localparam int SHORT_SLOPE_US    = 8750;
  localparam int LONG_CUT_US       = 5625;
  localparam int MIN_SLOPE_US      = 1250;

  // Output rates in kHz, index from CFG.
  localparam int RATE_KHZ [0:4] = '{8, 16, 32, 48, 12};
  localparam int CELP_KHZ_LO    = 12;  // 12.8 kHz handled as 12, so rates up to 12 kHz count as below it.

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [1:0] {
    MODE_NONE  = 2'b00,
    MODE_ONE   = 2'b01,
    MODE_TWO   = 2'b10,
    MODE_THREE = 2'b11
  } trans_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_MEMUPD = 3'b001,
    ST_HEAD   = 3'b010,
    ST_FADE   = 3'b011,
    ST_TAIL   = 3'b100
  } xf_state_t;

  typedef struct packed {
    logic        valid;
    logic [15:0] xfm;
    logic [15:0] lowrate;
    logic [15:0] pred;
    logic [15:0] alias_mem;
  } sample_in_t;

  typedef struct packed {
    logic        clear_mems;
    logic        load_fixed;
    logic        force_tc;
    logic        end_lpc_only;
    logic        refresh_lowrate;
    logic        extrapolate;
  } mem_cmd_t;

  localparam logic [15:0] SAMPLE_ZERO = 16'h0000;
  localparam logic [15:0] Q15_ONE     = 16'h7FFF;

endpackage : xfade_pkg

// ===== testbench/xfade_core_monitor.sv
// Purpose: Port-level relations of the transform/prediction switch block.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes:   Sees only the block's ports; mode is inferred from mem_cmd.
`timescale 1ns/1ps
module xfade_core_monitor (
  input wire logic                  clk,
  input wire logic                  resetn,
  input wire logic                  hsel,
  input wire logic [1:0]            htrans,
  input wire logic                  hwrite,
  input wire logic                  hready,
  input wire logic [31:0]           hrdata,
  input wire logic                  hreadyout,
  input wire logic                  hresp,
  input wire xfade_pkg::sample_in_t smp_in,
  input wire logic                  smp_out_valid,
  input wire logic                  lowrate_out_valid,
  input wire xfade_pkg::mem_cmd_t   mem_cmd,
  input wire logic                  mem_cmd_valid
);
  logic rd_dp_q;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) rd_dp_q <= 1'b0;
    else rd_dp_q <= hsel & hready & htrans[1] & ~hwrite;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_cmd_pulse;
    mem_cmd_valid ##1 !mem_cmd_valid;
  endsequence
  sequence s_sample;
    smp_in.valid ##1 smp_out_valid;
  endsequence
  a_ready_always: assert property (hreadyout) else $error("hreadyout low");
  a_okay_only: assert property (!hresp) else $error("hresp not OKAY");
  a_rdata_idle: assert property (!rd_dp_q |-> hrdata == 32'h0) else $error("hrdata not zero");
  a_out_follows: assert property (smp_out_valid |-> $past(smp_in.valid)) else $error("output without input");
  a_cmd_pulse: assert property (mem_cmd_valid |-> s_cmd_pulse) else $error("command pulse too long");
  a_cmd_hold: assert property ($changed(mem_cmd) |-> mem_cmd_valid) else $error("command changed alone");
  a_lowrate_mode: assert property (lowrate_out_valid |-> mem_cmd.refresh_lowrate) else $error("low rate out");
  a_tc_group: assert property (mem_cmd.force_tc |-> mem_cmd.clear_mems && mem_cmd.load_fixed
    && mem_cmd.end_lpc_only) else $error("mode one set incomplete");
  a_extrap_excl: assert property (mem_cmd.extrapolate |-> !mem_cmd.clear_mems) else $error("both");
  c_sample: cover property (s_sample);
endmodule // xfade_core_monitor
bind xfade_core xfade_core_monitor u_mon (.clk, .resetn, .hsel, .htrans, .hwrite, .hready, .hrdata, .hreadyout,
  .hresp, .smp_in, .smp_out_valid, .lowrate_out_valid, .mem_cmd, .mem_cmd_valid);

// ===== testbench/sample_source.sv
// Purpose: Upstream synthesis stages: one sample per valid pulse.
// Assumes: go is a one-cycle request from the bench.
// Notes:   Data lines invert every cycle outside valid, so a value taken one cycle late never matches.
`timescale 1ns/1ps
module sample_source (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        go,
  input  wire logic [15:0] x,
  input  wire logic [15:0] p,
  input  wire logic [15:0] a,
  input  wire logic [15:0] l,
  output xfade_pkg::sample_in_t smp
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) smp <= '0;
    else if (go) smp <= {1'b1, x, l, p, a};
    else smp <= {1'b0, ~smp.xfm, ~smp.lowrate, ~smp.pred, ~smp.alias_mem};
  end
endmodule // sample_source

// ===== testbench/xfade_core_bench.sv
// Purpose: Self-checking bench for the switch block.
// Assumes: hready is the slave's own hreadyout.
// Notes:   Fade inputs are equal, so Q15 rounding needs a slack of two.
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; $display("CHECK FAILED %0t differs", $time); end end
module xfade_core_bench;
  logic clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, go = 1'b0, hready, hreadyout, hresp;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd, seed = 32'h754E7757;
  logic [15:0] sx = 16'h0, sp = 16'h0, sa = 16'h0, sl = 16'h0, smp_out, lowrate_out;
  logic        smp_out_valid, lowrate_out_valid, mem_cmd_valid, full_overlap, slope_trunc, slope_soften;
  logic        short_inv_en, zero_pad_en;
  xfade_pkg::sample_in_t smp_in;
  xfade_pkg::mem_cmd_t   mem_cmd;
  int          mismatches = 0, n_tests = 0, frames = 0, i, r;
  logic [15:0] exp_q[$];
  assign hready = hreadyout;
  always #50 clk = ~clk;
  sample_source u_src (.clk(clk), .resetn(resetn), .go(go), .x(sx), .p(sp), .a(sa), .l(sl), .smp(smp_in));
  xfade_core u_dut (.clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .smp_in(smp_in), .smp_out(smp_out), .smp_out_valid(smp_out_valid), .lowrate_out(lowrate_out),
    .lowrate_out_valid(lowrate_out_valid), .mem_cmd(mem_cmd), .mem_cmd_valid(mem_cmd_valid),
    .full_overlap(full_overlap), .slope_trunc(slope_trunc), .slope_soften(slope_soften),
    .short_inv_en(short_inv_en), .zero_pad_en(zero_pad_en));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task close_out;
    if (mismatches == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task hang;
    mismatches++;
    close_out;
  endtask
  // Address phase, then data phase; read data is taken at the falling edge inside the data phase.
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int t, ph;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    for (ph = 0; ph < 2; ph++) begin
      t = 0;
      do begin
        @(negedge clk);
        rd = hrdata;
        t++;
      end while (hreadyout !== 1'b1 && t < 50);
      if (t >= 50) hang;
      @(posedge clk);
      if (ph == 0) begin
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
      end
    end
  endtask
  task sample(input int n, input logic [1:0] mode, input int dl, input int de);
    logic [15:0] x, p, a, l, e, tol;
    int t;
    seed = lfsr(seed);
    x = {4'h0, seed[11:0]} | 16'h0010;
    p = (mode == 2'h2 && n < de) ? x : {4'h0, seed[23:12]};
    a = {8'h00, seed[31:24]};
    l = ~x;
    tol = (mode == 2'h2 && n >= dl && n < de) ? 16'h0002 : 16'h0000;
    exp_q.push_back(n < de ? x : (mode == 2'h2 ? p : a + p));
    @(posedge clk);
    {sx, sp, sa, sl} <= {x, p, a, l};
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    t = 0;
    do begin
      @(negedge clk);
      t++;
      if (lowrate_out_valid === 1'b1) `CHK(lowrate_out, l)
    end while (smp_out_valid !== 1'b1 && t < 20);
    if (t >= 20) hang;
    e = exp_q.pop_front();
    `CHK(smp_out >= e - tol && smp_out <= e + tol, 1'b1)
  endtask
  task frame(input logic [1:0] mode, input logic ext, input int khz, input logic probe);
    int dl, de, n, t;
    dl = khz / 4;
    de = (khz == 8) ? 10 : (23125 * khz) / 10000;
    bus(1'b1, xfade_pkg::ADDR_CFG, (khz == 8) ? 32'h1 : 32'h2);
    bus(1'b1, xfade_pkg::ADDR_CTRL, {27'h0, ext, mode == 2'h1, mode, 1'b1});
    t = 0;
    do begin
      @(negedge clk);
      t++;
    end while (mem_cmd_valid !== 1'b1 && t < 20);
    if (t >= 20) hang;
    if (mode == 2'h1) `CHK(mem_cmd, 6'b111100)
    else if (mode == 2'h2) `CHK({mem_cmd.refresh_lowrate, mem_cmd.clear_mems}, 2'b10)
    else `CHK(mem_cmd.extrapolate, ext)
    for (n = 0; n < 20 * khz; n++) begin
      sample(n, mode, dl, de);
      if (probe && n == 5) bus(1'b1, xfade_pkg::ADDR_CFG, 32'hF0);
    end
    frames++;
    bus(1'b0, xfade_pkg::ADDR_STATUS, 32'h0);
    `CHK(rd[18:0], {xfade_pkg::ST_IDLE, frames[15:0]})
    if (probe) bus(1'b0, xfade_pkg::ADDR_CFG, 32'h0);
    if (probe) `CHK(rd, 32'h1)
  endtask
  initial begin
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    bus(1'b0, xfade_pkg::ADDR_CFG, 32'h0);
    `CHK(rd, xfade_pkg::CFG_RESET)
    bus(1'b1, 8'h20, 32'hFFFFFFFF);
    bus(1'b0, 8'h20, 32'h0);
    `CHK(rd, 32'h0)
    for (i = 0; i < 16; i++) begin
      r = i % 5;
      bus(1'b1, xfade_pkg::ADDR_CFG, {24'h0, i[3:0], r[2:0], r == 0});
      @(negedge clk);
      `CHK(full_overlap, i[0] ^ i[1])
      `CHK({slope_trunc, slope_soften}, {2{i[0] & ~i[1]}})
      `CHK(short_inv_en, i[0] | i[1])
      `CHK(zero_pad_en, r == 0 || r == 4)
    end
    frame(2'h1, 1'b0, 8, 1'b0);
    frame(2'h2, 1'b0, 16, 1'b0);
    frame(2'h2, 1'b0, 8, 1'b1);
    frame(2'h3, 1'b1, 8, 1'b0);
    frame(2'h3, 1'b0, 8, 1'b0);
    close_out;
  end
endmodule // xfade_core_bench
